// ### ssf_pkg.sv
// Package of constants and types for the system status flag bank.
`default_nettype none
package ssf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SSF_OFS_ERR   = 8'h00;
  localparam logic [7:0] SSF_OFS_LOG   = 8'h04;
  localparam logic [7:0] SSF_OFS_MODE  = 8'h08;
  localparam logic [7:0] SSF_OFS_PORT  = 8'h0c;
  localparam logic [7:0] SSF_OFS_ISTAT = 8'h10;
  localparam logic [7:0] SSF_OFS_IMASK = 8'h14;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SSF_PORT_LANE  = 8;
  localparam int unsigned SSF_NPORTS_DEF = 2;
  localparam int unsigned SSF_NPORTS_MAX = 4;
  localparam int unsigned SSF_NERR_IRQ   = 5;
  localparam logic        SSF_FLAG_RST   = 1'b0;

  typedef struct packed {
    logic io_bus_error_flag;
    logic system_error_flag;
    logic watchdog_error_flag;
    logic inspect_error_flag;
    logic op_error_latched_flag;
    logic op_error_flag;
  } ssf_err_t;

  typedef struct packed {
    logic state_log_clear;
    logic download_log_clear;
    logic error_log_clear;
  } ssf_log_t;

  typedef struct packed {
    logic rx_done;
    logic width_select;
    logic rx_timeout;
    logic rx_error;
    logic rx_complete;
    logic wait_reply;
    logic send_flag;
  } ssf_port_t;

  typedef struct packed {
    logic rx_done;
    logic rx_timeout;
    logic rx_error;
    logic rx_complete;
    logic wait_reply;
    logic send_done;
  } ssf_port_in_t;

  typedef struct packed {
    logic io_bus_error;
    logic system_error;
    logic watchdog_error;
    logic inspect_error;
    logic op_fail;
    logic op_done;
  } ssf_err_in_t;

  localparam ssf_err_t  SSF_ERR_RST  = '{default: SSF_FLAG_RST};
  localparam ssf_log_t  SSF_LOG_RST  = '{default: SSF_FLAG_RST};
  localparam ssf_port_t SSF_PORT_RST = '{default: SSF_FLAG_RST};

endpackage
`default_nettype wire

// ### ssf_bank.sv
// System status flag bank with APB register access and interrupt.
`timescale 1ns/1ps
`default_nettype none
module ssf_bank
  import ssf_pkg::*;
#(
  parameter int unsigned NPORTS = SSF_NPORTS_DEF
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  input  wire logic                     run_mode,
  input  wire ssf_err_in_t              err_in,
  input  wire logic                     online_edit_active,
  input  wire logic                     debug_active,
  input  wire ssf_port_in_t [NPORTS-1:0] port_in,
  output var  ssf_err_t                 err_flags,
  output var  ssf_log_t                 log_clear,
  output var  logic                     online_edit_flag,
  output var  logic                     debug_mode_flag,
  output var  ssf_port_t [NPORTS-1:0]   port_flags,
  output var  logic                     irq
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (NPORTS < 1 || NPORTS > SSF_NPORTS_MAX) begin : g_bad
    $error("NPORTS must lie between one and four.");
  end

  localparam int unsigned NIRQ = SSF_NERR_IRQ + 3 * NPORTS;

  // Read/write flag update; the hardware set wins over any clear.
  function automatic logic upd(input logic cur, input logic hw_set,
                               input logic wr, input logic wbit,
                               input logic clr);
    logic v;
    v = wr ? wbit : cur;
    return hw_set | (v & ~clr);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                   run_ff;
  ssf_err_t               err_ff;
  ssf_err_t               nxt_err;
  ssf_log_t               log_ff;
  ssf_log_t               nxt_log;
  logic                   edit_ff;
  logic                   dbg_ff;
  ssf_port_t [NPORTS-1:0] port_ff;
  ssf_port_t [NPORTS-1:0] nxt_port;
  logic [NIRQ-1:0]        istat_ff;
  logic [NIRQ-1:0]        nxt_istat;
  logic [NIRQ-1:0]        imask_ff;
  logic [NIRQ-1:0]        nxt_imask;
  logic [NIRQ-1:0]        irq_ev;
  logic                   irq_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic [31:0]            prdata_ff;
  logic [31:0]            rd_word;
  logic [31:0]            port_word;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic acc_first = psel & penable & ~pready_ff;
  wire logic acc_done  = psel & penable & pready_ff;
  wire logic wr_done   = acc_done & pwrite;
  wire logic hit_err   = (paddr == SSF_OFS_ERR);
  wire logic hit_log   = (paddr == SSF_OFS_LOG);
  wire logic hit_mode  = (paddr == SSF_OFS_MODE);
  wire logic hit_port  = (paddr == SSF_OFS_PORT);
  wire logic hit_istat = (paddr == SSF_OFS_ISTAT);
  wire logic hit_imask = (paddr == SSF_OFS_IMASK);
  wire logic hit_any   = hit_err | hit_log | hit_mode | hit_port | hit_istat | hit_imask;
  wire logic wr_log    = wr_done & hit_log;
  wire logic wr_port   = wr_done & hit_port;
  wire logic wr_imask  = wr_done & hit_imask;
  wire logic rd_istat  = acc_first & ~pwrite & hit_istat;
  wire logic run_entry = run_mode & ~run_ff;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    // Operation error tracks each finished operation, the latch keeps it.
    nxt_err.op_error_flag = upd(err_ff.op_error_flag, 1'b0, err_in.op_done,
                                err_in.op_fail, run_entry);
    nxt_err.op_error_latched_flag = upd(err_ff.op_error_latched_flag,
                                        err_in.op_done & err_in.op_fail,
                                        1'b0, 1'b0, run_entry);
    nxt_err.inspect_error_flag  = err_in.inspect_error | (err_ff.inspect_error_flag & ~run_entry);
    nxt_err.watchdog_error_flag = err_in.watchdog_error | err_ff.watchdog_error_flag;
    nxt_err.system_error_flag   = err_in.system_error | err_ff.system_error_flag;
    nxt_err.io_bus_error_flag   = err_in.io_bus_error | err_ff.io_bus_error_flag;
    nxt_log.error_log_clear    = upd(log_ff.error_log_clear, 1'b0, wr_log, pwdata[0], 1'b0);
    nxt_log.download_log_clear = upd(log_ff.download_log_clear, 1'b0, wr_log, pwdata[1], 1'b0);
    nxt_log.state_log_clear    = upd(log_ff.state_log_clear, 1'b0, wr_log, pwdata[2], 1'b0);
    for (int p = 0; p < NPORTS; p++) begin
      // Software starts a send; the port clears it once the send is over.
      nxt_port[p].send_flag = wr_port ? pwdata[p*SSF_PORT_LANE]
                            : (port_ff[p].send_flag & ~port_in[p].send_done & ~run_entry);
      nxt_port[p].wait_reply = port_in[p].wait_reply & ~run_entry;
      nxt_port[p].rx_complete = upd(port_ff[p].rx_complete, port_in[p].rx_complete, wr_port,
                                    pwdata[p*SSF_PORT_LANE+2], run_entry);
      nxt_port[p].rx_error = port_in[p].rx_error | (port_ff[p].rx_error & ~run_entry);
      nxt_port[p].rx_timeout = upd(port_ff[p].rx_timeout, port_in[p].rx_timeout, wr_port,
                                   pwdata[p*SSF_PORT_LANE+4], run_entry);
      nxt_port[p].width_select = upd(port_ff[p].width_select, 1'b0, wr_port,
                                     pwdata[p*SSF_PORT_LANE+5], 1'b0);
      nxt_port[p].rx_done = upd(port_ff[p].rx_done, port_in[p].rx_done, wr_port,
                                pwdata[p*SSF_PORT_LANE+6], 1'b0);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    irq_ev = '0;
    irq_ev[0] = err_in.op_done & err_in.op_fail;
    irq_ev[1] = err_in.inspect_error;
    irq_ev[2] = err_in.watchdog_error;
    irq_ev[3] = err_in.system_error;
    irq_ev[4] = err_in.io_bus_error;
    for (int p = 0; p < NPORTS; p++) begin
      irq_ev[SSF_NERR_IRQ + 3*p]     = port_in[p].rx_complete;
      irq_ev[SSF_NERR_IRQ + 3*p + 1] = port_in[p].rx_error;
      irq_ev[SSF_NERR_IRQ + 3*p + 2] = port_in[p].rx_timeout;
    end
    // A read clears what it returned; an event in the same cycle survives.
    nxt_istat = irq_ev | (istat_ff & ~{NIRQ{rd_istat}});
    nxt_imask = wr_imask ? pwdata[NIRQ-1:0] : imask_ff;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    port_word = '0;
    for (int p = 0; p < NPORTS; p++) begin
      port_word[p*SSF_PORT_LANE +: SSF_PORT_LANE] = {1'b0, port_ff[p]};
    end
    rd_word = '0;
    if (hit_err) begin
      rd_word[$bits(ssf_err_t)-1:0] = err_ff;
    end
    if (hit_log) begin
      rd_word[$bits(ssf_log_t)-1:0] = log_ff;
    end
    if (hit_mode) begin
      rd_word[1:0] = {dbg_ff, edit_ff};
    end
    if (hit_port) begin
      rd_word = port_word;
    end
    if (hit_istat) begin
      rd_word[NIRQ-1:0] = istat_ff;
    end
    if (hit_imask) begin
      rd_word[NIRQ-1:0] = imask_ff;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Writes to read-only words are dropped; undefined offsets answer with an error.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc_first;
      pslverr_ff <= acc_first & ~hit_any;
      prdata_ff  <= (acc_first & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_ff   <= SSF_FLAG_RST;
      err_ff   <= SSF_ERR_RST;
      log_ff   <= SSF_LOG_RST;
      edit_ff  <= SSF_FLAG_RST;
      dbg_ff   <= SSF_FLAG_RST;
      port_ff  <= {NPORTS{SSF_PORT_RST}};
      istat_ff <= '0;
      imask_ff <= '0;
      irq_ff   <= 1'b0;
    end else begin
      run_ff   <= run_mode;
      err_ff   <= nxt_err;
      log_ff   <= nxt_log;
      edit_ff  <= online_edit_active;
      dbg_ff   <= debug_active;
      port_ff  <= nxt_port;
      istat_ff <= nxt_istat;
      imask_ff <= nxt_imask;
      irq_ff   <= |(nxt_istat & nxt_imask);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign err_flags        = err_ff;
  assign log_clear        = log_ff;
  assign online_edit_flag = edit_ff;
  assign debug_mode_flag  = dbg_ff;
  assign port_flags       = port_ff;
  assign irq              = irq_ff;

endmodule
`default_nettype wire

// ### ssf_bank_properties.sv
// Port-level checks for the status flag bank.
`timescale 1ns/1ps
`default_nettype none
module ssf_bank_properties
  import ssf_pkg::*;
#(
  parameter int unsigned NPORTS = SSF_NPORTS_DEF
) (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      run_mode,
  input wire logic                      online_edit_active,
  input wire logic                      debug_active,
  input wire ssf_err_t                  err_flags,
  input wire ssf_log_t                  log_clear,
  input wire logic                      online_edit_flag,
  input wire logic                      debug_mode_flag,
  input wire ssf_port_t [NPORTS-1:0]    port_flags,
  input wire logic                      irq
);
  // ----
  // Helpers
  // ----
  wire logic acc = psel && penable && !pready;
  wire logic done = psel && penable && pready && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ready_one_wait_a: assert property (acc |=> pready) else $error("no pready after access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  edit_follow_a: assert property ($rose(online_edit_active) |=> online_edit_flag) else $error("edit flag");
  debug_drop_a: assert property ($fell(debug_active) |=> !debug_mode_flag) else $error("debug flag");
  latched_hold_a: assert property (err_flags.op_error_latched_flag && $stable(run_mode) ##1 $stable(run_mode)
    |-> err_flags.op_error_latched_flag) else $error("latched error lost");
  watchdog_hold_a: assert property (err_flags.watchdog_error_flag |=> err_flags.watchdog_error_flag)
    else $error("watchdog flag lost");
  width_hold_a: assert property (!(done && paddr == SSF_OFS_PORT) |=> $stable(port_flags[0].width_select))
    else $error("width select moved");
  log_hold_a: assert property (!(done && paddr == SSF_OFS_LOG) |=> $stable(log_clear))
    else $error("log clear moved");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property ($fell(err_flags.op_error_latched_flag));
endmodule
bind ssf_bank ssf_bank_properties #(.NPORTS(NPORTS)) i_props (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .run_mode(run_mode), .online_edit_active(online_edit_active), .debug_active(debug_active),
  .err_flags(err_flags), .log_clear(log_clear), .online_edit_flag(online_edit_flag),
  .debug_mode_flag(debug_mode_flag), .port_flags(port_flags), .irq(irq));
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the status flag bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssf_pkg::*;
  logic               clk, rst_n, psel, penable, pwrite, run_mode, ed, dbg, pready, pslverr, irq, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd, w;
  ssf_err_in_t        err_in;
  ssf_port_in_t [1:0] port_in;
  logic [11:0]        wl;
  ssf_log_t           lc;
  ssf_err_t           ef;
  ssf_port_t [1:0]    pf;
  logic               oef, dmf;
  int                 fails, tests_run;
  ssf_bank #(.NPORTS(2)) i_ssf_bank (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_mode(run_mode), .err_in(err_in), .online_edit_active(ed), .debug_active(dbg), .port_in(port_in),
    .err_flags(ef), .log_clear(lc), .online_edit_flag(oef), .debug_mode_flag(dmf), .port_flags(pf), .irq(irq));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ev(input ssf_err_in_t e, input logic [11:0] p);
    @(posedge clk);
    err_in <= e;
    port_in <= p | wl;
    @(posedge clk);
    err_in <= '0;
    port_in <= wl;
    repeat (2) @(posedge clk);
  endtask
  task automatic run_entry();
    @(posedge clk);
    run_mode <= 1'b0;
    @(posedge clk);
    run_mode <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic results();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // The whole sequence takes well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    {rst_n, psel, penable, pwrite, run_mode, ed, dbg, paddr, pwdata, err_in, port_in, wl} = '0;
    fails = 0;
    tests_run = 0;
    void'($urandom(44));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 24; a += 4) rdchk(8'(a), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset and map test done");
    w = $urandom & 32'h7;
    apb(1'b1, SSF_OFS_LOG, w);
    run_entry();
    rdchk(SSF_OFS_LOG, w);
    chk(32'(lc), w);
    $display("log clear test done");
    apb(1'b1, SSF_OFS_IMASK, 32'h1);
    ev(6'h03, 12'h0);
    chk({31'h0, irq}, 32'h1);
    ev(6'h0c, 12'h0);
    apb(1'b1, SSF_OFS_ERR, 32'hffffffff);
    rdchk(SSF_OFS_ERR, 32'h0f);
    rdchk(SSF_OFS_ISTAT, 32'h07);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    ev(6'h01, 12'h0);
    rdchk(SSF_OFS_ERR, 32'h0e);
    run_entry();
    rdchk(SSF_OFS_ERR, 32'h08);
    chk(32'(ef), 32'h08);
    $display("error flag test done");
    w = $urandom & 32'h3;
    ed <= w[0];
    dbg <= w[1];
    repeat (2) @(posedge clk);
    rdchk(SSF_OFS_MODE, w);
    chk({30'h0, dmf, oef}, w);
    $display("mode test done");
    w = $urandom & 32'h7f7f;
    apb(1'b1, SSF_OFS_PORT, w);
    wl = 12'h002;
    ev('0, 12'h204);
    rdchk(SSF_OFS_PORT, (w & 32'h7575) | 32'h0806);
    rdchk(SSF_OFS_ISTAT, 32'h220);
    wl = 12'h0;
    ev('0, 12'h0);
    run_entry();
    rdchk(SSF_OFS_PORT, w & 32'h6060);
    chk(32'(pf), 32'({w[14:8] & 7'h60, w[6:0] & 7'h60}));
    $display("port flag test done");
    results();
  end
endmodule
`default_nettype wire
